// *** common/shdp_pkg.sv ***
// Package of operation codes, bit positions and carrier types for the shifter.
package shdp_pkg;

    // ==========================================================
    // Widths and amount field positions (LSB-0 indices).
    localparam int SHDP_XLEN = 64;
    localparam int SHDP_WLEN = 32;
    localparam int SHDP_AMT_W = 6;
    localparam int SHDP_DW_OVR_BIT = 6;
    localparam int SHDP_W_OVR_BIT = 5;
    localparam logic [4:0] SHDP_ZERO_AMT5 = 5'h00;
    localparam logic [5:0] SHDP_ZERO_AMT6 = 6'h00;

    // ==========================================================
    // Register offsets (byte addresses).
    localparam logic [7:0] SHDP_OFF_CTRL = 8'h00;
    localparam logic [7:0] SHDP_OFF_SRC_LO = 8'h04;
    localparam logic [7:0] SHDP_OFF_SRC_HI = 8'h08;
    localparam logic [7:0] SHDP_OFF_AMT = 8'h0C;
    localparam logic [7:0] SHDP_OFF_RES_LO = 8'h10;
    localparam logic [7:0] SHDP_OFF_RES_HI = 8'h14;
    localparam logic [7:0] SHDP_OFF_FLAGS = 8'h18;
    localparam logic [31:0] SHDP_UNMAPPED = 32'h00000000;
    localparam logic [1:0] SHDP_RESP_OKAY = 2'h0;
    localparam logic [1:0] SHDP_RESP_SLVERR = 2'h2;

    // ==========================================================
    // Control register field positions.
    localparam int SHDP_CTRL_OP_LSB = 0;
    localparam int SHDP_CTRL_REC = 4;
    localparam int SHDP_CTRL_CM = 5;
    localparam int SHDP_CTRL_SO = 6;
    localparam int SHDP_CTRL_IMM_LSB = 8;

    // Operation selection.
    typedef enum logic [2:0] {
        SHDP_OP_SLD,
        SHDP_OP_SLW,
        SHDP_OP_SRADI,
        SHDP_OP_SRAW,
        SHDP_OP_SRAWI,
        SHDP_OP_SRD
    } shdp_op_t;

    // Condition field: negative, positive, zero, overflow summary.
    typedef struct packed {
        logic negative_flag;
        logic positive_flag;
        logic zero_flag;
        logic summary;
    } shdp_cond_t;

    // Result bundle produced by the datapath.
    typedef struct packed {
        logic [63:0] dest_reg;
        logic shift_out_flag;
        logic cond_valid;
        shdp_cond_t condition_field_zero;
    } shdp_res_t;

endpackage

// *** design/shdp_top.sv ***
// Shift datapath with an AXI4-Lite register front end.
//
// Behaviour
// - sld shifts by amount bits 58:63; amount bit 57 set gives zero.
// - Left shifts zero-fill low positions and drop bits leaving the top.
// - Doubleword logical shift amounts 64..127 give a zero result.
// - slw shifts low source word by amount bits 59:63; bit 58 zeroes it.
// - slw result sits in bits 32:63; bits 0:31 are cleared.
// - slw amounts 32..63 give an all-zero destination.
// - sradi amount is sh5 above sh0:4; fill with source bit 0.
// - sradi flag set only for negative source losing a one bit.
// - sradi zero amount copies source and clears the flag.
// - Word arithmetic shifts sign from bit 32, filling bits 0:31 too.
// - sraw amounts 32..63 give all sign bits; flag equals sign.
// - Word arithmetic flag set when negative word loses a one bit.
// - Word arithmetic zero amount gives sign-extended low word, flag clear.
// - srawi behaves as sraw using immediate bits sh0:4; sh5 is ignored.
// - srd shifts by amount bits 58:63; amount bit 57 set gives zero.
// - Right logical shifts zero-fill high positions, dropping bits off bottom.
// - Record bit sets cond_valid; negative, positive, zero and summary bits are written whatever its value.
`timescale 1ns/1ps
`default_nettype none
module shdp_top (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Write address and data channels.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import shdp_pkg::*;

    // ==========================================================
    // Datapath function. Documented bit i maps to vector bit 63-i.
    // Source bit 0 is vector bit 63, bit 32 is vector bit 31.
    function automatic shdp_res_t shift_eval(input shdp_op_t op,
            input logic [63:0] src, input logic [6:0] amt,
            input logic [5:0] imm, input logic rec, input logic cm,
            input logic so);
        logic [63:0] res;
        logic [63:0] lost;
        logic [31:0] w;
        logic [63:0] wext;
        logic ws;
        logic ca;
        logic [5:0] n6;
        logic [4:0] n5;
        logic big;
        shdp_res_t o;
        res = '0;
        lost = '0;
        w = src[SHDP_WLEN-1:0];
        ws = src[SHDP_WLEN-1];
        wext = {{SHDP_WLEN{ws}}, w};
        ca = 1'b0;
        n6 = amt[SHDP_AMT_W-1:0];
        n5 = amt[4:0];
        big = 1'b0;
        case (op)
            SHDP_OP_SLD: begin
                // Amount bit 57 is vector bit 6.
                if (amt[SHDP_DW_OVR_BIT]) begin
                    res = '0;
                end else begin
                    res = src << n6;
                end
            end
            SHDP_OP_SRD: begin
                if (amt[SHDP_DW_OVR_BIT]) begin
                    res = '0;
                end else begin
                    res = src >> n6;
                end
            end
            SHDP_OP_SLW: begin
                // Amount bit 58 is vector bit 5.
                if (amt[SHDP_W_OVR_BIT]) begin
                    res = '0;
                end else begin
                    res = {32'h00000000, w << n5};
                end
            end
            SHDP_OP_SRADI: begin
                // Immediate is assembled sh5 || sh0:4 by decode.
                n6 = imm;
                res = $signed(src) >>> n6;
                lost = src & ~({SHDP_XLEN{1'b1}} << n6);
                ca = src[SHDP_XLEN-1] && (lost != '0);
            end
            SHDP_OP_SRAW, SHDP_OP_SRAWI: begin
                if (op == SHDP_OP_SRAWI) begin
                    big = 1'b0;
                    n5 = imm[4:0];
                end else begin
                    big = amt[SHDP_W_OVR_BIT];
                end
                if (big) begin
                    res = {SHDP_XLEN{ws}};
                    ca = ws;
                end else begin
                    res = $signed(wext) >>> n5;
                    lost = {32'h00000000,
                        w & ~({SHDP_WLEN{1'b1}} << n5)};
                    ca = ws && (lost != '0);
                end
            end
            default: begin
                res = '0;
            end
        endcase
        o.dest_reg = res;
        o.shift_out_flag = ca;
        o.cond_valid = rec;
        // Signed compare width follows computation mode.
        if (cm) begin
            o.condition_field_zero.negative_flag = res[63];
            o.condition_field_zero.zero_flag = (res == '0);
        end else begin
            o.condition_field_zero.negative_flag = res[31];
            o.condition_field_zero.zero_flag = (res[31:0] == '0);
        end
        o.condition_field_zero.positive_flag =
            !o.condition_field_zero.negative_flag &&
            !o.condition_field_zero.zero_flag;
        o.condition_field_zero.summary = so;
        return o;
    endfunction

    // ==========================================================
    // Register state.
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [63:0] src_r, src_nxt;
    logic [6:0] amt_r, amt_nxt;
    shdp_res_t res_r, res_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wr_go;
    logic rd_go;
    shdp_op_t op_sel;

    // Write accepted only when both address and data are present.
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign rd_go = s_axi_arvalid && !rvalid_r;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign op_sel = shdp_op_t'(ctrl_r[SHDP_CTRL_OP_LSB +: 3]);

    // Next-state logic for registers, datapath result and bus answers.
    always_comb begin
        ctrl_nxt = ctrl_r;
        src_nxt = src_r;
        amt_nxt = amt_r;
        bvalid_nxt = bvalid_r && !s_axi_bready;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (wr_go) begin
            bvalid_nxt = 1'b1;
            bresp_nxt = SHDP_RESP_OKAY;
            case (s_axi_awaddr)
                SHDP_OFF_CTRL: ctrl_nxt = s_axi_wdata;
                SHDP_OFF_SRC_LO: src_nxt[31:0] = s_axi_wdata;
                SHDP_OFF_SRC_HI: src_nxt[63:32] = s_axi_wdata;
                SHDP_OFF_AMT: amt_nxt = s_axi_wdata[6:0];
                default: bresp_nxt = SHDP_RESP_SLVERR;
            endcase
        end
        // Result recomputed every cycle from the held operands.
        res_nxt = shift_eval(op_sel, src_r, amt_r,
            ctrl_r[SHDP_CTRL_IMM_LSB +: 6], ctrl_r[SHDP_CTRL_REC],
            ctrl_r[SHDP_CTRL_CM], ctrl_r[SHDP_CTRL_SO]);
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = SHDP_RESP_OKAY;
            case (s_axi_araddr)
                SHDP_OFF_CTRL: rdata_nxt = ctrl_r;
                SHDP_OFF_SRC_LO: rdata_nxt = src_r[31:0];
                SHDP_OFF_SRC_HI: rdata_nxt = src_r[63:32];
                SHDP_OFF_AMT: rdata_nxt = {25'h0000000, amt_r};
                SHDP_OFF_RES_LO: rdata_nxt = res_r.dest_reg[31:0];
                SHDP_OFF_RES_HI: rdata_nxt = res_r.dest_reg[63:32];
                SHDP_OFF_FLAGS: rdata_nxt = {26'h0000000,
                    res_r.shift_out_flag, res_r.cond_valid,
                    res_r.condition_field_zero};
                default: begin
                    rdata_nxt = SHDP_UNMAPPED;
                    rresp_nxt = SHDP_RESP_SLVERR;
                end
            endcase
        end
    end

    // Registers all take their next values on every rising edge outside reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= '0;
            src_r <= '0;
            amt_r <= '0;
            res_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rresp_r <= 2'h0;
            rdata_r <= 32'h00000000;
        end else begin
            ctrl_r <= ctrl_nxt;
            src_r <= src_nxt;
            amt_r <= amt_nxt;
            res_r <= res_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ==========================================================
    // Checks on the registered result and on the write response hold.
    a_sld_overflow: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ($past(op_sel) == SHDP_OP_SLD && $past(amt_r[6]))
        |-> res_r.dest_reg == '0)
        else $error("Doubleword left shift overflow not zero.");
    a_slw_upper: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ($past(op_sel) == SHDP_OP_SLW) |-> res_r.dest_reg[63:32] == '0)
        else $error("Word left shift upper half not cleared.");
    a_sraw_big: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ($past(op_sel) == SHDP_OP_SRAW && $past(amt_r[5]))
        |-> res_r.shift_out_flag == $past(src_r[31]))
        else $error("Word arithmetic big shift flag wrong.");
    a_sradi_zero: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ($past(op_sel) == SHDP_OP_SRADI && $past(ctrl_r[13:8]) == 6'h00)
        |-> res_r.dest_reg == $past(src_r) && !res_r.shift_out_flag)
        else $error("Zero amount arithmetic shift altered source.");
    a_word_sign: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ($past(op_sel) == SHDP_OP_SRAWI)
        |-> res_r.dest_reg[63:32] == {32{$past(src_r[31])}})
        else $error("Word arithmetic upper half not sign.");
    a_srd_overflow: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ($past(op_sel) == SHDP_OP_SRD && $past(amt_r[6]))
        |-> res_r.dest_reg == '0)
        else $error("Doubleword right shift overflow not zero.");
    a_cond_summary: assert property (@(posedge aclk)
        disable iff (!aresetn)
        1'b1 |-> res_r.condition_field_zero.summary == $past(ctrl_r[6]))
        else $error("Condition summary bit not copied.");
    a_slw_big: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ($past(op_sel) == SHDP_OP_SLW && $past(amt_r[5]))
        |-> res_r.dest_reg == '0)
        else $error("Word left shift big amount not zero.");
    a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("Write response dropped early.");

    // A zero sraw amount must give the sign-extended low word, flag clear.
    a_word_zero: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ($past(op_sel) == SHDP_OP_SRAW && $past(amt_r[5:0]) == SHDP_ZERO_AMT6)
        |-> res_r.dest_reg == {{32{$past(src_r[31])}}, $past(src_r[31:0])}
            && !res_r.shift_out_flag)
        else $error("Word arithmetic zero amount result wrong.");
    // A non-negative sradi source can never raise the shift-out flag.
    a_sradi_flag: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ($past(op_sel) == SHDP_OP_SRADI && !$past(src_r[63]))
        |-> !res_r.shift_out_flag)
        else $error("Shift-out flag set for non-negative source.");
    // Every accepted read is answered on the following edge.
    a_read_answer: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("Read answer missing after address taken.");
endmodule
`default_nettype wire

// *** bench/shdp_axi_master.sv ***
// Register bus master model that drives the shifter's register bus.
`timescale 1ns/1ps
`default_nettype none
module shdp_axi_master (
    // Clock.
    input wire logic aclk,
    // Write channels.
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels.
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready,
    // High once an answer never came.
    output logic hung
);
    // Bus starts idle.
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready, hung} = '0;
    end

    // Readies are sampled mid-cycle, where they are settled, and acted on
    // at the next rising edge; a released payload shows its inverse.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic ta, tw, tb;
        int i;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        for (i = 0; i < 100; i++) begin
            @(negedge aclk);
            {ta, tw, tb, r} = {awvalid & awready, wvalid & wready,
                               bvalid, bresp};
            @(posedge aclk);
            if (ta) {awaddr, awvalid} <= {~a, 1'h0};
            if (tw) {wdata, wvalid} <= {~d, 1'h0};
            if (tb) begin
                bready <= 1'h0;
                break;
            end
        end
        if (i == 100) hung <= 1'h1;
    endtask

    // Read: same sampling scheme, data taken with the answer.
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic ta, tr;
        int i;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        for (i = 0; i < 100; i++) begin
            @(negedge aclk);
            {ta, tr, r, d} = {arvalid & arready, rvalid, rresp, rdata};
            @(posedge aclk);
            if (ta) {araddr, arvalid} <= {~a, 1'h0};
            if (tr) begin
                rready <= 1'h0;
                break;
            end
        end
        if (i == 100) hung <= 1'h1;
    endtask
endmodule
`default_nettype wire

// *** bench/test_shift_datapath.sv ***
// Self-checking bench for the shifter behind its register bus.
`timescale 1ns/1ps
`default_nettype none
module test_shift_datapath;
    import shdp_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, hung;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, acc;
    int n_mismatch = 0;
    int n_checks = 0;

    shdp_top shdp_top_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready)
    );
    shdp_axi_master shdp_axi_master_inst (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .hung(hung)
    );

    // Free-running 250 MHz clock.
    initial aclk = 1'h0;
    always #2 aclk = ~aclk;

    // Compares under a mask and counts the outcome.
    task automatic cmp(input logic [63:0] g, input logic [63:0] e,
                       input logic [63:0] m);
        n_checks++;
        if ((g & m) !== (e & m)) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h",
                     $time, g & m, e & m);
        end
    endtask

    // Reads one word, gathering its response code.
    task automatic get(input logic [7:0] a, output logic [31:0] d);
        logic [1:0] r;
        shdp_axi_master_inst.rd(a, d, r);
        acc = acc | r;
    endtask

    // Writes one word, gathering its response code.
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        shdp_axi_master_inst.wr(a, d, r);
        acc = acc | r;
    endtask

    // Expected {shift-out, record, negative, positive, zero, summary, result}.
    function automatic logic [69:0] model(input logic [2:0] o,
        input logic [63:0] s, input logic [6:0] a, input logic [5:0] im,
        input logic [2:0] f);
        logic [63:0] r, x, m;
        logic [5:0] n;
        logic c, ng, z;
        x = (o == 3'h2) ? s : {{32{s[31]}}, s[31:0]};
        n = (o == 3'h2) ? im : (o == 3'h4) ? {1'h0, im[4:0]}
            : a[5] ? 6'h20 : {1'h0, a[4:0]};
        m = (64'h1 << n) - 64'h1;
        c = x[63] & (|(x & m));
        r = $signed(x) >>> n;
        if (o == 3'h0) r = a[6] ? '0 : s << a[5:0];
        if (o == 3'h1) r = a[5] ? '0 : {32'h0, s[31:0] << a[4:0]};
        if (o == 3'h5) r = a[6] ? '0 : s >> a[5:0];
        ng = f[1] ? r[63] : r[31];
        z = f[1] ? (r == '0) : (r[31:0] == '0);
        return {c, f[2], ng, !ng && !z, z, f[0], r};
    endfunction

    // Loads operands, lets the result settle, then judges it; f holds
    // record, 64-bit mode and summary.
    task automatic go(input logic [2:0] o, input logic [63:0] s,
        input logic [6:0] a, input logic [5:0] im, input logic [2:0] f);
        logic [69:0] e;
        logic [31:0] hi, lo, fl;
        e = model(o, s, a, im, f);
        acc = 2'h0;
        put(SHDP_OFF_SRC_HI, s[63:32]);
        put(SHDP_OFF_SRC_LO, s[31:0]);
        put(SHDP_OFF_AMT, {25'h0, a});
        put(SHDP_OFF_CTRL, {18'h0, im, 1'h0, f[0], f[1], f[2], 1'h0, o});
        repeat (2) @(posedge aclk);
        get(SHDP_OFF_RES_HI, hi);
        get(SHDP_OFF_RES_LO, lo);
        get(SHDP_OFF_FLAGS, fl);
        cmp({hi, lo}, e[63:0], '1);
        cmp(64'(fl), 64'(e[69:64]),
            {58'h0, (o inside {3'h2, 3'h3, 3'h4}), 1'h1, {4{f[2]}}});
        cmp(64'(acc), 64'(SHDP_RESP_OKAY), 64'h3);
    endtask

    // Register bus: reset contents, then an unmapped write and read.
    task automatic t_bus();
        logic [31:0] d;
        acc = 2'h0;
        get(SHDP_OFF_RES_LO, d);
        cmp({30'h0, acc, d}, 64'h0, '1);
        put(SHDP_OFF_AMT, 32'hFFFFFFFF);
        get(SHDP_OFF_AMT, d);
        cmp({30'h0, acc, d}, 64'h7F, '1);
        put(SHDP_OFF_SRC_LO, 32'h01234567);
        get(SHDP_OFF_SRC_LO, d);
        cmp({30'h0, acc, d}, 64'h01234567, '1);
        put(SHDP_OFF_SRC_HI, 32'h89ABCDEF);
        get(SHDP_OFF_SRC_HI, d);
        cmp({30'h0, acc, d}, 64'h89ABCDEF, '1);
        put(SHDP_OFF_CTRL, 32'hA5A53F77);
        get(SHDP_OFF_CTRL, d);
        cmp({30'h0, acc, d}, 64'hA5A53F77, '1);
        // An undefined operation code leaves a zero result.
        get(SHDP_OFF_RES_HI, d);
        cmp({30'h0, acc, d}, 64'h0, '1);
        put(8'h40, 32'hA5A5A5A5);
        get(8'h40, d);
        cmp({30'h0, acc, d}, {30'h0, SHDP_RESP_SLVERR, 32'h0}, '1);
    endtask

    // Left shifts: full span, dropped top bits, over-range amounts.
    task automatic t_left();
        go(SHDP_OP_SLD, 64'h8000000000000001, 7'h3F, 6'h0, 3'h6);
        go(SHDP_OP_SLD, 64'hF0F0F0F0F0F0F0F1, 7'h04, 6'h0, 3'h7);
        go(SHDP_OP_SLD, 64'hFFFFFFFFFFFFFFFF, 7'h7F, 6'h0, 3'h6);
        go(SHDP_OP_SLW, 64'hFFFFFFFF80000001, 7'h1F, 6'h0, 3'h4);
        go(SHDP_OP_SLW, 64'h123456789ABCDEF1, 7'h20, 6'h0, 3'h6);
        go(SHDP_OP_SLW, 64'h0000000140000000, 7'h41, 6'h0, 3'h6);
    endtask

    // Arithmetic right shifts: sign fill, shift-out flag, zero amounts.
    task automatic t_arith();
        go(SHDP_OP_SRADI, 64'h8000000000000001, 7'h7F, 6'h21, 3'h6);
        go(SHDP_OP_SRADI, 64'h8000000000000000, 7'h0, 6'h3F, 3'h6);
        go(SHDP_OP_SRADI, 64'hFFFFFFFFFFFFFFFF, 7'h0, 6'h00, 3'h6);
        go(SHDP_OP_SRADI, 64'h7FFFFFFFFFFFFFFF, 7'h0, 6'h04, 3'h6);
        go(SHDP_OP_SRAW, 64'h0000000080000001, 7'h04, 6'h0, 3'h4);
        go(SHDP_OP_SRAW, 64'h0000000080000000, 7'h28, 6'h0, 3'h6);
        go(SHDP_OP_SRAW, 64'hFFFFFFFF7FFFFFFF, 7'h3F, 6'h0, 3'h4);
        go(SHDP_OP_SRAW, 64'h0000000080000005, 7'h40, 6'h0, 3'h6);
        go(SHDP_OP_SRAWI, 64'h00000000F0000003, 7'h3F, 6'h02, 3'h6);
        go(SHDP_OP_SRAWI, 64'hFFFFFFFF00000007, 7'h0, 6'h25, 3'h4);
    endtask

    // Right logical shifts: zero fill, bit 57 override, zero amount.
    task automatic t_right();
        go(SHDP_OP_SRD, 64'h8000000000000001, 7'h3F, 6'h0, 3'h6);
        go(SHDP_OP_SRD, 64'hFFFFFFFFFFFFFFFF, 7'h40, 6'h0, 3'h6);
        go(SHDP_OP_SRD, 64'h8000000000000000, 7'h00, 6'h0, 3'h5);
        go(SHDP_OP_SRD, 64'hF0F0F0F0F0F0F0F0, 7'h04, 6'h0, 3'h2);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // A bus answer that never came ends the run as a mismatch.
    always @(posedge hung) begin
        n_mismatch++;
        final_report();
    end

    // Reset for five cycles, then every scenario in turn.
    initial begin
        aresetn = 1'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        t_bus();
        t_left();
        t_arith();
        t_right();
        final_report();
    end
endmodule
`default_nettype wire
